// ---- rtl/spi_fram_slave_status_interface.sv ----
`timescale 1ns/1ps
module spi_fram_slave_status_interface (
    // Core clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Serial link pins
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       si,
    input  wire logic       hold_n,
    input  wire logic       write_protect_n,
    output logic            so_out,
    output logic            so_oe,
    // Status view for the core
    output logic [7:0]      protection_status_reg,
    output logic            sleep_active
);
    import fram_spi_pkg::*;

    // ==================================================
    // Declarations, link side
    link_state_e       state_reg;
    link_state_e       state_next;
    logic [2:0]        bit_cnt_reg;
    logic [7:0]        shift_reg;
    logic [7:0]        tx_byte_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic              is_write_reg;
    logic              lat_set_tgl_reg;
    logic              lat_clr_tgl_reg;
    logic              stat_wr_tgl_reg;
    logic [7:0]        stat_wr_data_reg;
    logic              sleep_arm_reg;
    logic [7:0]        shadow_reg;
    logic [2:0]        pub_sync_reg;
    logic [1:0]        sleep_sync_reg;

    // Declarations, core side
    logic [5:0]        ev_meta_reg;
    logic [5:0]        ev_sync_reg;
    logic [5:0]        ev_prev_reg;
    logic [7:0]        status_next;
    logic              pub_tgl_reg;
    logic              sleep_used_reg;

    // ==================================================
    // Link decode
    wire              link_active = hold_n & ~sleep_sync_reg[1] & ~cs_n;
    wire [7:0]        byte_in     = {shift_reg[6:0], si};
    wire              byte_done   = link_active & (bit_cnt_reg == BIT_LAST);
    wire              opc_done    = byte_done & (state_reg == st_opcode);
    wire [1:0]        bp_field    = shadow_reg[BP_HI_BIT:BP_LO_BIT];
    wire              so_float    = cs_n | ~hold_n;
    wire              pub_seen    = pub_sync_reg[2] ^ pub_sync_reg[1];
    wire [ADDR_W-1:0] addr_inc    = addr_reg + 13'h0001;

    // Block protect range from bits 3:2 of the shadow copy
    wire addr_protected = (bp_field == 2'b11) |
                          ((bp_field == 2'b10) & (addr_reg >= PROT_HALF_BASE)) |
                          ((bp_field == 2'b01) & (addr_reg >= PROT_QUARTER_BASE));

    // Memory write needs the latch and an unprotected address
    wire              mem_we    = byte_done & (state_reg == st_wr_data) &
                                  shadow_reg[LAT_BIT] & ~addr_protected;
    wire [ADDR_W-1:0] mem_raddr = (state_reg == st_addr_lo) ?
                                  {addr_reg[12:8], byte_in} : addr_inc;
    wire [7:0]        mem_rdata;

    // ==================================================
    // Phase sequencing; only the status read and write opcodes and memory access matter
    always_comb begin
        state_next = state_reg;
        if (byte_done) begin
            case (state_reg)
                st_opcode: begin
                    case (byte_in)
                        OP_RD_STAT: state_next = st_rd_stat;
                        OP_WR_STAT: state_next = st_wr_stat;
                        OP_RD_MEM:  state_next = st_addr_hi;
                        OP_WR_MEM:  state_next = st_addr_hi;
                        default:    state_next = st_ignore;
                    endcase
                end
                st_addr_hi: state_next = st_addr_lo;
                st_addr_lo: state_next = is_write_reg ? st_wr_data : st_rd_data;
                st_wr_stat: state_next = st_ignore;
                default:    state_next = state_reg;
            endcase
        end
    end

    // ==================================================
    // Frame registers: chip select high clears them, so every frame opens on an opcode
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            state_reg    <= st_opcode;
            bit_cnt_reg  <= BIT_FIRST;
            shift_reg    <= 8'h00;
            is_write_reg <= 1'b0;
        end else if (link_active) begin
            state_reg    <= state_next;
            bit_cnt_reg  <= bit_cnt_reg + 3'h1;
            shift_reg    <= byte_in;
            if (opc_done) begin
                is_write_reg <= (byte_in == OP_WR_MEM);
            end
        end
    end

    // Address and transmit byte; the address keeps counting through the array and wraps
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            addr_reg    <= 13'h0000;
            tx_byte_reg <= 8'h00;
        end else if (byte_done) begin
            if (state_reg == st_addr_hi) begin
                addr_reg[12:8] <= byte_in[4:0];
            end else if (state_reg == st_addr_lo) begin
                addr_reg[7:0] <= byte_in;
            end else if ((state_reg == st_wr_data) | (state_reg == st_rd_data)) begin
                addr_reg <= addr_inc;
            end
            if (state_next == st_rd_stat) begin
                tx_byte_reg <= shadow_reg;
            end else if (state_next == st_rd_data) begin
                tx_byte_reg <= mem_rdata;
            end
        end
    end

    // ==================================================
    // Latch and status-write events leave the link as toggles, sleep as a held flag; they survive the frame end
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            lat_set_tgl_reg  <= 1'b0;
            lat_clr_tgl_reg  <= 1'b0;
            stat_wr_tgl_reg  <= 1'b0;
            stat_wr_data_reg <= STATUS_RESET;
            sleep_arm_reg    <= 1'b0;
        end else if (link_active) begin
            lat_set_tgl_reg <= lat_set_tgl_reg ^ (opc_done & (byte_in == OP_LAT_SET));
            lat_clr_tgl_reg <= lat_clr_tgl_reg ^ (opc_done & (byte_in == OP_LAT_CLR));
            sleep_arm_reg   <= opc_done & (byte_in == OP_SLEEP);
            if (byte_done & (state_reg == st_wr_stat)) begin
                stat_wr_data_reg <= byte_in;
                stat_wr_tgl_reg  <= ~stat_wr_tgl_reg;
            end
        end
    end

    // Status copy for the link: taken when the core's publish toggle arrives
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            pub_sync_reg   <= 3'h0;
            sleep_sync_reg <= 2'h0;
            shadow_reg     <= STATUS_RESET;
        end else begin
            pub_sync_reg   <= {pub_sync_reg[1:0], pub_tgl_reg};
            sleep_sync_reg <= {sleep_sync_reg[0], sleep_active};
            if (pub_seen) begin
                shadow_reg <= protection_status_reg;
            end
        end
    end

    // ==================================================
    // Serial output on the falling edge; same edges serve mode 0 and mode 3
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            so_out <= 1'b0;
        end else begin
            so_out <= tx_byte_reg[~bit_cnt_reg];
        end
    end

    // Output enable drops at once on deselect or hold
    always_ff @(negedge sck or posedge so_float) begin
        if (so_float) begin
            so_oe <= 1'b0;
        end else begin
            so_oe <= ((state_reg == st_rd_stat) | (state_reg == st_rd_data)) &
                     ~sleep_sync_reg[1];
        end
    end

    fram_cell_array u_cells (
        .sck   (sck),
        .we    (mem_we),
        .waddr (addr_reg),
        .wdata (byte_in),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // ==================================================
    // Core side: pins and toggles each pass two flip-flops
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_sync
            wire ev_src;
            if (g == 0) begin : g_src
                assign ev_src = lat_set_tgl_reg;
            end else if (g == 1) begin : g_src
                assign ev_src = lat_clr_tgl_reg;
            end else if (g == 2) begin : g_src
                assign ev_src = stat_wr_tgl_reg;
            end else if (g == 3) begin : g_src
                assign ev_src = sleep_arm_reg;
            end else if (g == 4) begin : g_src
                assign ev_src = cs_n;
            end else begin : g_src
                assign ev_src = write_protect_n;
            end
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    ev_meta_reg[g] <= (g >= 4); // Pins idle high: no false edge after reset
                    ev_sync_reg[g] <= (g >= 4);
                    ev_prev_reg[g] <= (g >= 4);
                end else begin
                    ev_meta_reg[g] <= ev_src;
                    ev_sync_reg[g] <= ev_meta_reg[g];
                    ev_prev_reg[g] <= ev_sync_reg[g];
                end
            end
        end
    endgenerate

    // Core event decode
    wire lat_up_ev = ev_sync_reg[0] ^ ev_prev_reg[0];
    wire lat_dn_ev = ev_sync_reg[1] ^ ev_prev_reg[1];
    wire st_wr_ev  = ev_sync_reg[2] ^ ev_prev_reg[2];
    wire sleep_arm = ev_sync_reg[3];
    wire cs_rise   = ev_sync_reg[4] & ~ev_prev_reg[4];
    wire cs_fall   = ev_prev_reg[4] & ~ev_sync_reg[4];
    wire wp_high   = ev_sync_reg[5];
    wire wake_ev   = cs_fall & sleep_active;
    wire sleep_ev  = cs_rise & sleep_arm & ~sleep_used_reg;

    // Status writable only with the latch set and not locked by bit 7 with pin low
    wire status_wr_ok = protection_status_reg[LAT_BIT] &
                        ~(protection_status_reg[LOCK_BIT] & ~wp_high);

    // Next status: nonvolatile bits from a granted write, latch from commands
    always_comb begin
        status_next = protection_status_reg;
        if (st_wr_ev & status_wr_ok) begin
            status_next = (stat_wr_data_reg & STATUS_NV_MASK) |
                          (protection_status_reg & ~STATUS_NV_MASK);
        end
        if (lat_up_ev) begin
            status_next[LAT_BIT] = 1'b1;
        end
        if (lat_dn_ev | wake_ev) begin
            status_next[LAT_BIT] = 1'b0;
        end
        status_next[ZERO_BIT] = 1'b0;
    end

    // Status and sleep registers; every change is published to the link
    always_ff @(posedge core_clk) begin
        if (rst) begin
            protection_status_reg <= STATUS_RESET;
            pub_tgl_reg           <= 1'b0;
            sleep_active          <= 1'b0;
            sleep_used_reg        <= 1'b0;
        end else begin
            protection_status_reg <= status_next;
            pub_tgl_reg           <= pub_tgl_reg ^ (status_next != protection_status_reg);
            if (sleep_ev) begin
                sleep_active <= 1'b1;
            end else if (cs_fall) begin
                sleep_active <= 1'b0;
            end
            sleep_used_reg <= sleep_arm & (sleep_used_reg | sleep_ev);
        end
    end

    // ==================================================
    // Checks
    a_latch_set_cmd: assert property (
        @(posedge core_clk) disable iff (rst)
        lat_up_ev && !lat_dn_ev && !wake_ev |=> protection_status_reg[LAT_BIT])
        else $error("enable latch not set by set command");

    a_latch_clear_cmd: assert property (
        @(posedge core_clk) disable iff (rst)
        (lat_dn_ev || wake_ev) |=> !protection_status_reg[LAT_BIT])
        else $error("enable latch not cleared");

    a_latch_stays_set: assert property (
        @(posedge core_clk) disable iff (rst)
        protection_status_reg[LAT_BIT] && !lat_dn_ev && !wake_ev
        |=> protection_status_reg[LAT_BIT])
        else $error("enable latch dropped without a clear");

    a_status_locked: assert property (
        @(posedge core_clk) disable iff (rst)
        st_wr_ev && !status_wr_ok |=> $stable(protection_status_reg[7:2]))
        else $error("refused status write changed the register");

    a_status_written: assert property (
        @(posedge core_clk) disable iff (rst)
        st_wr_ev && status_wr_ok
        |=> protection_status_reg[7:2] == $past(stat_wr_data_reg[7:2]))
        else $error("granted status write not stored");

    a_bit0_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        st_wr_ev && stat_wr_data_reg[ZERO_BIT] |=> !protection_status_reg[ZERO_BIT])
        else $error("status bit 0 took a written one");

    a_standby_float: assert property (
        @(posedge core_clk) disable iff (rst)
        cs_n |-> !so_oe)
        else $error("output driven while deselected");

    a_hold_freeze: assert property (
        @(posedge sck) disable iff (cs_n)
        !hold_n ##1 !hold_n |-> $stable(bit_cnt_reg) && $stable(shift_reg))
        else $error("transfer moved during hold");

    a_opcode_decode: assert property (
        @(posedge sck) disable iff (cs_n)
        opc_done && byte_in == OP_RD_STAT |=> state_reg == st_rd_stat)
        else $error("status read opcode not decoded");

    a_full_protect: assert property (
        @(posedge sck) disable iff (cs_n)
        state_reg == st_wr_data && bp_field == 2'b11 |-> !mem_we)
        else $error("write reached a protected array");

endmodule : spi_fram_slave_status_interface

// ---- rtl/fram_spi_pkg.sv ----
// What this block does
// - Memory array of 8,192 bytes reached through the serial link.
// - Link runs in SPI mode 0 or mode 3, master's choice.
// - Input bits taken on rising clock edge, output changes on falling edge.
// - Chip select high means standby, output floating, other inputs ignored.
// - Hold low suspends transfer, floats output, clock and input ignored.
// - Device is only a slave; master may join input and output lines.
// - Status bit 7 guards status writes together with the protect pin.
// - Status bits 6 to 4 are spare, writable and read back.
// - Status bits 3 and 2 select the block protected from memory writes.
// - Bit 1 is the enable latch, set by command, cleared by command or on wake.
// - Enable latch cleared at power-on, by clear command, on sleep return.
// - Enable latch stays set after status write or memory write.
// - Status bit 0 always reads zero and ignores writes.
// - Decode the four status opcodes; select rising mid-opcode cancels.
// - Status read shifts out eight bits, repeating while clocks continue.
// - Protect field: none, top quarter, top half, or whole array.
// - Latch clear refuses writes; status writable unless bit 7 set, pin low.
package fram_spi_pkg;

    // ==================================================
    // Array geometry
    localparam int ARRAY_DEPTH = 8192;
    localparam int ADDR_W      = 13;
    localparam int DATA_W      = 8;

    // ==================================================
    // Opcodes
    localparam logic [7:0] OP_LAT_SET = 8'h06;
    localparam logic [7:0] OP_LAT_CLR = 8'h04;
    localparam logic [7:0] OP_RD_STAT = 8'h05;
    localparam logic [7:0] OP_WR_STAT = 8'h01;
    localparam logic [7:0] OP_RD_MEM  = 8'h03;
    localparam logic [7:0] OP_WR_MEM  = 8'h02;
    localparam logic [7:0] OP_SLEEP   = 8'hb9;

    // ==================================================
    // Status register layout and reset
    localparam int         LOCK_BIT     = 7;
    localparam int         BP_HI_BIT    = 3;
    localparam int         BP_LO_BIT    = 2;
    localparam int         LAT_BIT      = 1;
    localparam int         ZERO_BIT     = 0;
    localparam logic [7:0] STATUS_NV_MASK = 8'hfc;
    localparam logic [7:0] STATUS_RESET   = 8'h00;

    // ==================================================
    // Block protect boundaries and counts
    localparam logic [12:0] PROT_QUARTER_BASE = 13'h1800;
    localparam logic [12:0] PROT_HALF_BASE    = 13'h1000;
    localparam logic [2:0]  BIT_LAST          = 3'h7;
    localparam logic [2:0]  BIT_FIRST         = 3'h0;

    // ==================================================
    // Link phase, one-hot
    typedef enum logic [7:0] {
        st_opcode  = 8'h01,
        st_addr_hi = 8'h02,
        st_addr_lo = 8'h04,
        st_wr_data = 8'h08,
        st_rd_data = 8'h10,
        st_rd_stat = 8'h20,
        st_wr_stat = 8'h40,
        st_ignore  = 8'h80
    } link_state_e;

endpackage : fram_spi_pkg

// ---- rtl/fram_cell_array.sv ----
`timescale 1ns/1ps
module fram_cell_array (
    // Write side, on the serial clock
    input  wire logic                              sck,
    input  wire logic                              we,
    input  wire logic [fram_spi_pkg::ADDR_W-1:0]   waddr,
    input  wire logic [fram_spi_pkg::DATA_W-1:0]   wdata,
    // Read side, combinational so data is ready before the next falling edge
    input  wire logic [fram_spi_pkg::ADDR_W-1:0]   raddr,
    output logic      [fram_spi_pkg::DATA_W-1:0]   rdata
);
    import fram_spi_pkg::*;

    // ==================================================
    // Storage
    logic [DATA_W-1:0] cells [0:ARRAY_DEPTH-1];

    // Byte write on the rising edge that completes the data byte
    always_ff @(posedge sck) begin
        if (we) begin
            cells[waddr] <= wdata;
        end
    end

    // Async read keeps the first output bit one half-clock away from the address
    assign rdata = cells[raddr];

endmodule : fram_cell_array

// ---- tb/spi_master_model.sv ----
`timescale 1ns/1ps
module spi_master_model (
    // Serial link pins driven by the master
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    output logic      hold_n,
    // Serial output of the device
    input  wire logic so_out,
    input  wire logic so_oe
);
    // ==================================================
    // Link timing and mode
    localparam time HALF = 24ns;
    logic mode3;
    logic last_so;

    // Select rises just after time zero, a clean edge that clears the frame logic
    initial begin
        mode3   = 1'b0;
        last_so = 1'b0;
        sck     = 1'b0;
        cs_n    = 1'b0;
        si      = 1'b0;
        hold_n  = 1'b1;
        #1;
        cs_n    = 1'b1;
    end

    // ==================================================
    // Frame control
    // Park the clock first, so a mode change never looks like an edge
    task automatic frame_begin();
        sck = mode3;
        #HALF;
        cs_n = 1'b0;
        #HALF;
    endtask : frame_begin

    // Select rises with the clock parked high, then the clock goes idle
    task automatic frame_end();
        cs_n = 1'b1;
        si   = ~si;  // Released line shows no stale value
        #HALF;
        sck = mode3;
        #HALF;
    endtask : frame_end

    // Shift n bits MSB first into q[7:8-n]; a floating output reads inverted
    task automatic send_bits(input logic [7:0] d, input int n, output logic [7:0] q);
        q = 8'h00;
        for (int i = 7; i >= 8 - n; i--) begin
            sck = 1'b0;
            si  = d[i];
            #HALF;
            sck     = 1'b1;
            last_so = so_oe ? so_out : ~last_so;
            q[i]    = last_so;
            #HALF;
        end
    endtask : send_bits

    // Hold entered and left with the clock low, garbage clocked meanwhile
    task automatic hold_gap();
        sck = 1'b0;
        #HALF;
        hold_n = 1'b0;
        repeat (3) begin
            si  = ~si;
            sck = 1'b1;
            #HALF;
            sck = 1'b0;
            #HALF;
        end
        hold_n = 1'b1;
        #HALF;
    endtask : hold_gap

endmodule : spi_master_model

// ---- tb/spi_fram_slave_status_interface_tb_top.sv ----
`timescale 1ns/1ps
module spi_fram_slave_status_interface_tb_top;
    import fram_spi_pkg::*;

    // ==================================================
    // Clock, reset and pins
    logic       core_clk;
    logic       rst;
    logic       write_protect_n;
    logic       sck;
    logic       cs_n;
    logic       si;
    logic       hold_n;
    logic       so_out;
    logic       so_oe;
    logic [7:0] protection_status_reg;
    logic       sleep_active;
    logic [7:0] got [4];
    int         mismatches = 0;
    int         samples_checked = 0;
    int         cycles = 0;

    spi_fram_slave_status_interface u_dut (
        .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
        .hold_n(hold_n), .write_protect_n(write_protect_n), .so_out(so_out),
        .so_oe(so_oe), .protection_status_reg(protection_status_reg),
        .sleep_active(sleep_active));

    spi_master_model u_master (
        .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_out(so_out), .so_oe(so_oe));

    // Core clock, 20 ns period
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // A hung link is cut short far beyond the expected run length
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    // ==================================================
    // Reporting and helpers
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic check_byte(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_byte

    task automatic check_bit(input string what, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask : check_bit

    // Core-side inputs move 2 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : tick

    // One frame of n bytes; the core gets time to take in any status change
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                         input logic [7:0] b3, input int n);
        logic [7:0] tx [4];
        tx = '{b0, b1, b2, b3};
        u_master.frame_begin();
        for (int k = 0; k < n; k++) begin
            u_master.send_bits(tx[k], 8, got[k]);
        end
        u_master.frame_end();
        tick(10);
    endtask : frame

    // ==================================================
    // Scenarios
    task automatic t_modes();
        for (int m = 0; m < 2; m++) begin
            u_master.mode3 = m[0];
            frame(8'h06, 8'h00, 8'h00, 8'h00, 1);  // Latch set opcode
            check_bit("latch set", protection_status_reg[1], 1'b1);
            frame(OP_RD_STAT, 8'h00, 8'h00, 8'h00, 3);
            check_byte("status read", got[1], 8'h02);
            check_byte("status repeat", got[2], 8'h02);
            check_bit("so idle", so_oe, 1'b0);
            frame(8'h04, 8'h00, 8'h00, 8'h00, 1);  // Latch clear opcode
            check_byte("latch cleared", protection_status_reg, 8'h00);
        end
    endtask : t_modes

    // Status writes: refused, accepted, and locked by the protect pin
    task automatic t_status_write();
        frame(OP_WR_STAT, 8'hff, 8'h00, 8'h00, 2);
        check_byte("write no latch", protection_status_reg, 8'h00);
        frame(8'h06, 8'h00, 8'h00, 8'h00, 1);
        frame(OP_WR_STAT, 8'hff, 8'h00, 8'h00, 2);
        check_byte("write all ones", protection_status_reg, 8'hfe);
        frame(OP_RD_STAT, 8'h00, 8'h00, 8'h00, 2);
        check_byte("read after write", got[1], 8'hfe);
        tick(1);
        write_protect_n = 1'b0;
        frame(OP_WR_STAT, 8'h00, 8'h00, 8'h00, 2);
        check_byte("locked write", protection_status_reg, 8'hfe);
        tick(1);
        write_protect_n = 1'b1;
        frame(OP_WR_STAT, 8'h00, 8'h00, 8'h00, 2);
        check_byte("unlocked write", protection_status_reg, 8'h02);
    endtask : t_status_write

    // Select rising one bit short of an opcode cancels it and resets the count
    task automatic t_cancel();
        u_master.frame_begin();
        u_master.send_bits(8'h04, 7, got[0]);
        u_master.frame_end();
        tick(10);
        check_bit("cancelled clear", protection_status_reg[1], 1'b1);
        frame(OP_RD_STAT, 8'h00, 8'h00, 8'h00, 2);
        check_byte("fresh opcode", got[1], 8'h02);
    endtask : t_cancel

    // Hold in mid data byte must not disturb the bit position
    task automatic t_hold();
        u_master.frame_begin();
        u_master.send_bits(OP_WR_STAT, 8, got[0]);
        u_master.send_bits(8'hb0, 4, got[1]);
        u_master.hold_gap();
        u_master.send_bits(8'h00, 4, got[2]);
        u_master.frame_end();
        tick(10);
        check_byte("held write", protection_status_reg, 8'hb2);
        frame(OP_WR_STAT, 8'h00, 8'h00, 8'h00, 2);
    endtask : t_hold

    // Quarter and whole-array protection against memory writes
    task automatic t_protect();
        frame(OP_WR_MEM, 8'h1f, 8'hff, 8'h5a, 4);
        frame(OP_WR_MEM, 8'h00, 8'h00, 8'h77, 4);
        frame(OP_WR_STAT, 8'h04, 8'h00, 8'h00, 2);
        frame(OP_WR_MEM, 8'h1f, 8'hff, 8'ha5, 4);
        frame(OP_WR_MEM, 8'hf7, 8'hff, 8'hc3, 4);  // Upper address bits ignored
        frame(OP_RD_MEM, 8'h1f, 8'hff, 8'h00, 4);
        check_byte("top quarter", got[3], 8'h5a);
        frame(OP_RD_MEM, 8'h17, 8'hff, 8'h00, 4);
        check_byte("below quarter", got[3], 8'hc3);
        check_bit("latch kept", protection_status_reg[1], 1'b1);
        frame(OP_WR_STAT, 8'h0c, 8'h00, 8'h00, 2);
        frame(OP_WR_MEM, 8'h00, 8'h00, 8'h88, 4);
        frame(OP_RD_MEM, 8'h00, 8'h00, 8'h00, 4);
        check_byte("whole array", got[3], 8'h77);
        frame(OP_WR_STAT, 8'h00, 8'h00, 8'h00, 2);
    endtask : t_protect

    // Sleep entry with no trailing clock; wake clears the latch
    task automatic t_sleep();
        u_master.mode3 = 1'b1;
        frame(OP_SLEEP, 8'h00, 8'h00, 8'h00, 1);
        check_bit("sleep entered", sleep_active, 1'b1);
        u_master.frame_begin();
        u_master.frame_end();
        tick(10);
        check_bit("woken", sleep_active, 1'b0);
        check_bit("latch on wake", protection_status_reg[1], 1'b0);
    endtask : t_sleep

    // ==================================================
    // Main sequence
    initial begin
        rst             = 1'b0;
        write_protect_n = 1'b1;
        #1;
        rst = 1'b1;  // Rises after time zero so the link-side flops see the edge
        tick(20);
        rst = 1'b0;
        tick(3);
        check_byte("reset status", protection_status_reg, 8'h00);
        check_bit("so at reset", so_oe, 1'b0);
        t_modes();
        t_status_write();
        t_cancel();
        t_hold();
        t_protect();
        t_sleep();
        complete_run();
    end

endmodule : spi_fram_slave_status_interface_tb_top
